/* File: design/fst_pkg.sv */
// package for the flash suspend/terminate/reset control pair
// assumes: both ends and the bench compile this first
package fst_pkg;
  // ==========================================================
  // command codes
  localparam logic [7:0] CMD_SUSPEND = 8'h75;
  localparam logic [7:0] CMD_TERMINATE = 8'hF0;
  localparam logic [7:0] CMD_RESUME = 8'h7A;
  localparam logic [7:0] CMD_PROGRAM = 8'h02;
  localparam logic [7:0] CMD_ERASE = 8'h20;
  localparam logic [7:0] CMD_OTP_PROGRAM = 8'h9B;
  localparam logic [7:0] CMD_WRITE_STATUS = 8'h01;
  localparam logic [7:0] CMD_STATUS_LOCK = 8'h6F;
  localparam logic [7:0] CMD_RESET_ENABLE = 8'h66;
  localparam logic [7:0] CMD_RESET_DEVICE = 8'h99;
  // ==========================================================
  // security registers and pin-reset pattern
  localparam int OTP_COUNT = 4;
  localparam int OTP_BYTES = 128;
  localparam int LOCK_LSB = 3; // lock bits sit at 5:3 of status 2
  localparam logic [6:0] OTP_MSB_INDEX = 7'h7F;
  localparam logic [3:0] PIN_RESET_PATTERN = 4'h5;
  // ==========================================================
  // timing in link clock cycles (operation lengths), host divider in clock_in cycles
  localparam int SUSPEND_LATENCY_CYC = 20;
  localparam int TERMINATE_LATENCY_CYC = 10;
  localparam int PROGRAM_CYC = 200;
  localparam int ERASE_CYC = 400;
  localparam int NV_WRITE_CYC = 60;
  localparam int HOST_DIV = 2; // host link clock half period in clock_in cycles
endpackage : fst_pkg

/* File: design/fst_link_if.sv */
// serial link between host controller and flash control
// assumes: bench resolves the pins; host drives all but busy and status, which the device drives
`timescale 1ns/1ps
interface fst_link_if;
  logic sck; // serial clock, also device clock
  logic cs_n; // chip select, active low
  logic si; // serial input to device
  logic cmd_valid; // one-cycle command strobe on sck domain
  logic [7:0] cmd_code; // command opcode
  logic [8:0] cmd_addr; // address for security programming
  logic [7:0] cmd_data; // data byte
  logic busy; // device busy
  logic [5:0] status; // {pe,ee,ps,es,sl-any,ultra} device flags
  modport device (input sck, input cs_n, input si, input cmd_valid, input cmd_code,
    input cmd_addr, input cmd_data, output busy, output status);
  modport host (output sck, output cs_n, output si, output cmd_valid, output cmd_code,
    output cmd_addr, output cmd_data, input busy, input status);
endinterface : fst_link_if

/* File: design/fst_device.sv */
// flash suspend/terminate/reset control, documented device end
// assumes: link clock sck keeps toggling while commands/ops run;
// a free-running sample clock samples cs_n/si for pin reset
// Function
// - accept suspend and terminate during program
// - quiesce then set suspend or error flag
// - program flags follow suspend/terminate latency
// - terminate beats pending suspend, no resume
// - erase quiesce sets erase suspend/error
// - erase flags follow the two latencies
// - erase terminate beats suspend, no resume
// - terminate ignored after suspend completes
// - host checks suspend flags before program/erase
// - host erases terminated region before reprogramming; host sends program directly, no erase first
// - no program/erase while suspended
// - terminate ignored during nonvolatile register writes
// - resets postponed until nonvolatile write ends
// - four 128-byte otp registers, one factory locked
// - msb write locks otp, sets lock bit
// - address 8:7 selects, 6:0 indexes
// - cs edges sample 0101 means reset
// - host holds sck, alternates si
// - sck movement aborts pin reset
// - reset in ultra sleep clears buffer; no buffer modelled, reset acts as in other modes
// - other reset keeps buffer, clears volatile
// - nonvolatile status survives reset
// - reset returns single-line spi mode
// - new command clears error; reset clears; only program and nv writes clear pe, only erase clears ee
`timescale 1ns/1ps
module fst_device import fst_pkg::*; (
  input wire logic clock_in, // free sample clock for pin reset
  input wire logic rst_n_in, // power-on reset
  fst_link_if.device link,
  input wire logic ultra_sleep_in, // ultra_deep_sleep mode request
  input wire logic [1:0] lines_req_in, // multi-line mode request
  output logic [2:0] security_lock_bits_out, // otp lock bits
  output logic [1:0] lines_mode_out, // active transfer width code
  output logic reset_pulse_out, // pin-sequence reset detected (sample domain)
  output logic [7:0] otp_rdata_out // byte at last programmed address
);
  // ==========================================================
  // op state
  typedef enum {ST_IDLE, ST_PROG, ST_ERASE, ST_NV, ST_SUSP_WAIT, ST_TERM_WAIT} fst_state_e;
  fst_state_e state;
  logic [15:0] count; // remaining cycles of current phase
  logic [15:0] saved_count; // op cycles left when suspended
  logic op_is_erase; // current self-timed op is erase
  logic program_suspend_flag, erase_suspend_flag;
  logic program_error_flag, erase_error_flag;
  logic ultra_latched; // ultra sleep input, registered every sck
  logic reset_pending; // reset waiting for nv op end
  logic reset_armed; // reset enable seen
  logic [7:0] otp_mem [OTP_COUNT*OTP_BYTES]; // otp array
  logic [2:0] lock_bits; // nonvolatile, survive soft reset
  // ==========================================================
  // command decode
  wire cmd = link.cmd_valid;
  wire is_susp = cmd && link.cmd_code == CMD_SUSPEND;
  wire is_term = cmd && link.cmd_code == CMD_TERMINATE;
  wire is_res = cmd && link.cmd_code == CMD_RESUME;
  wire is_prog = cmd && link.cmd_code == CMD_PROGRAM;
  wire is_erase = cmd && link.cmd_code == CMD_ERASE;
  wire is_otp = cmd && link.cmd_code == CMD_OTP_PROGRAM;
  wire is_nvreg = cmd && (link.cmd_code == CMD_WRITE_STATUS || link.cmd_code == CMD_STATUS_LOCK);
  wire is_rst = cmd && link.cmd_code == CMD_RESET_DEVICE && reset_armed;
  wire any_susp = program_suspend_flag | erase_suspend_flag;
  wire [1:0] otp_sel = link.cmd_addr[8:7];
  wire [6:0] otp_idx = link.cmd_addr[6:0];
  wire otp_ok = otp_sel != 2'b00 && !lock_bits[otp_sel - 2'd1];
  wire idle_ready = state == ST_IDLE;
  // ==========================================================
  // pin-sequence reset crossing into the link domain
  logic pin_rst_tgl, pin_rst_s1, pin_rst_s2, pin_rst_s3;
  wire pin_rst_ev = pin_rst_s2 ^ pin_rst_s3;
  wire do_reset = (is_rst || pin_rst_ev || reset_pending) && state != ST_NV;
  // ==========================================================
  // main sequencer on link clock
  always_ff @(posedge link.sck or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= ST_IDLE;
      count <= 16'h0000;
      saved_count <= 16'h0000;
      op_is_erase <= 1'b0;
      program_suspend_flag <= 1'b0;
      erase_suspend_flag <= 1'b0;
      program_error_flag <= 1'b0;
      erase_error_flag <= 1'b0;
      reset_pending <= 1'b0;
      reset_armed <= 1'b0;
      lines_mode_out <= 2'h0;
    end else if (do_reset) begin
      // volatile state back to defaults, lock bits kept
      state <= ST_IDLE;
      program_suspend_flag <= 1'b0;
      erase_suspend_flag <= 1'b0;
      program_error_flag <= 1'b0;
      erase_error_flag <= 1'b0;
      reset_pending <= 1'b0;
      reset_armed <= 1'b0;
      lines_mode_out <= 2'h0;
    end else begin
      if (is_rst || pin_rst_ev) begin
        reset_pending <= 1'b1;
      end
      if (cmd) begin
        reset_armed <= link.cmd_code == CMD_RESET_ENABLE;
      end
      if (cmd && link.cmd_code == 8'h38) begin
        lines_mode_out <= lines_req_in;
      end
      case (state)
        ST_IDLE: begin
          if (is_prog && !any_susp) begin
            state <= ST_PROG;
            op_is_erase <= 1'b0;
            count <= 16'(PROGRAM_CYC);
            program_error_flag <= 1'b0;
          end else if (is_erase && !any_susp) begin
            state <= ST_ERASE;
            op_is_erase <= 1'b1;
            count <= 16'(ERASE_CYC);
            erase_error_flag <= 1'b0;
          end else if ((is_otp && otp_ok) || is_nvreg) begin
            state <= ST_NV;
            count <= 16'(NV_WRITE_CYC);
            program_error_flag <= 1'b0;
          end else if (is_res && any_susp) begin
            // resume continues the saved op
            state <= program_suspend_flag ? ST_PROG : ST_ERASE;
            count <= saved_count;
            op_is_erase <= !program_suspend_flag;
            program_suspend_flag <= 1'b0;
            erase_suspend_flag <= program_suspend_flag ? erase_suspend_flag : 1'b0;
          end
          // terminate while idle or suspended is ignored
        end
        ST_PROG, ST_ERASE: begin
          if (is_term) begin
            state <= ST_TERM_WAIT;
            count <= 16'(TERMINATE_LATENCY_CYC);
          end else if (is_susp) begin
            state <= ST_SUSP_WAIT;
            count <= 16'(SUSPEND_LATENCY_CYC);
            saved_count <= count;
          end else if (count <= 16'h0001) begin
            state <= ST_IDLE;
          end else begin
            count <= count - 16'h0001;
          end
        end
        ST_SUSP_WAIT: begin
          if (is_term) begin
            state <= ST_TERM_WAIT;
            count <= 16'(TERMINATE_LATENCY_CYC);
          end else if (count <= 16'h0001) begin
            state <= ST_IDLE;
            program_suspend_flag <= !op_is_erase;
            erase_suspend_flag <= op_is_erase | erase_suspend_flag;
          end else begin
            count <= count - 16'h0001;
          end
        end
        ST_TERM_WAIT: begin
          if (count <= 16'h0001) begin
            state <= ST_IDLE;
            // the other error flag is kept until a program/nv write (pe) or erase (ee) command or a reset clears it
            program_error_flag <= program_error_flag | !op_is_erase;
            erase_error_flag <= erase_error_flag | op_is_erase;
          end else begin
            count <= count - 16'h0001;
          end
        end
        ST_NV: begin
          // terminate ignored here
          if (count <= 16'h0001) begin
            state <= ST_IDLE;
          end else begin
            count <= count - 16'h0001;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
  // ==========================================================
  // otp array and lock bits, nonvolatile
  always_ff @(posedge link.sck or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lock_bits <= 3'h0;
      otp_rdata_out <= 8'h00;
    end else if (idle_ready && is_otp && otp_ok && !do_reset) begin
      otp_mem[{otp_sel, otp_idx}] <= link.cmd_data;
      otp_rdata_out <= link.cmd_data;
      if (otp_idx == OTP_MSB_INDEX) begin
        lock_bits[otp_sel - 2'd1] <= 1'b1;
      end
    end
  end
  always_ff @(posedge link.sck or negedge rst_n_in) begin
    if (!rst_n_in) begin
      security_lock_bits_out <= 3'h0;
      link.busy <= 1'b0;
      link.status <= 6'h00;
      ultra_latched <= 1'b0;
    end else begin
      security_lock_bits_out <= lock_bits;
      link.busy <= state != ST_IDLE;
      link.status <= {program_error_flag, erase_error_flag, program_suspend_flag,
        erase_suspend_flag, |lock_bits, ultra_latched};
      ultra_latched <= ultra_sleep_in; // buffer undefined, not modelled
    end
  end
  // ==========================================================
  // pin-sequence reset detector on sample clock
  logic cs_s1, cs_s2, si_s1, si_s2, sck_s1, sck_s2, cs_d, sck_d;
  logic [1:0] seq_n; // edges seen
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      // idle levels: cs high, si low, sck low, so no false edge
      {cs_s1, cs_s2, si_s1, si_s2, sck_s1, sck_s2, cs_d, sck_d} <= 8'hC2;
      seq_n <= 2'h0;
      pin_rst_tgl <= 1'b0;
      reset_pulse_out <= 1'b0;
    end else begin
      cs_s1 <= link.cs_n;
      cs_s2 <= cs_s1;
      si_s1 <= link.si;
      si_s2 <= si_s1;
      sck_s1 <= link.sck;
      sck_s2 <= sck_s1;
      cs_d <= cs_s2;
      sck_d <= sck_s2;
      reset_pulse_out <= 1'b0;
      if (sck_s2 != sck_d) begin
        seq_n <= 2'h0;
      end else if (cs_s2 && !cs_d) begin
        if (si_s2 == PIN_RESET_PATTERN[3 - seq_n]) begin
          seq_n <= seq_n + 2'h1;
          if (seq_n == 2'h3) begin
            pin_rst_tgl <= ~pin_rst_tgl;
            reset_pulse_out <= 1'b1;
          end
        end else begin
          seq_n <= si_s2 ? 2'h0 : 2'h1;
        end
      end
    end
  end
  always_ff @(posedge link.sck or negedge rst_n_in) begin
    if (!rst_n_in) begin
      {pin_rst_s1, pin_rst_s2, pin_rst_s3} <= 3'h0;
    end else begin
      pin_rst_s1 <= pin_rst_tgl;
      pin_rst_s2 <= pin_rst_s1;
      pin_rst_s3 <= pin_rst_s2;
    end
  end
endmodule : fst_device

/* File: design/fst_host.sv */
// host controller end: issues commands and the pin-sequence reset
// assumes: sck derived from clock_in by a divider
`timescale 1ns/1ps
module fst_host import fst_pkg::*; (
  input wire logic clock_in,
  input wire logic rst_n_in,
  fst_link_if.host link,
  input wire logic req_in, // one-cycle command request
  input wire logic [7:0] req_code_in, // opcode
  input wire logic [8:0] req_addr_in, // address
  input wire logic [7:0] req_data_in, // data
  input wire logic pin_reset_in, // start pin-sequence reset
  output logic ready_out, // may take a request
  output logic refused_out // program/erase refused by flags
);
  // ==========================================================
  // divider and state
  typedef enum {HS_RUN, HS_RST_LOW, HS_RST_HIGH} fst_hstate_e;
  fst_hstate_e hstate;
  logic [3:0] div;
  logic [2:0] pulse_n; // reset pulses done
  logic [7:0] hold_code;
  logic pending;
  logic [5:0] st_s1, st_s2; // synchronised status
  wire susp_set = st_s2[3] | st_s2[2];
  wire is_pe = req_code_in == CMD_PROGRAM || req_code_in == CMD_ERASE;
  wire block = is_pe && susp_set;
  wire half = div == 4'(HOST_DIV - 1);
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hstate <= HS_RUN;
      div <= 4'h0;
      pulse_n <= 3'h0;
      link.sck <= 1'b0;
      link.cs_n <= 1'b1;
      link.si <= 1'b0;
      link.cmd_valid <= 1'b0;
      link.cmd_code <= 8'h00;
      link.cmd_addr <= 9'h000;
      link.cmd_data <= 8'h00;
      hold_code <= 8'h00;
      pending <= 1'b0;
      ready_out <= 1'b0;
      refused_out <= 1'b0;
      st_s1 <= 6'h00;
      st_s2 <= 6'h00;
    end else begin
      st_s1 <= link.status;
      st_s2 <= st_s1;
      refused_out <= 1'b0;
      div <= half ? 4'h0 : div + 4'h1;
      case (hstate)
        HS_RUN: begin
          ready_out <= !pending && !pin_reset_in;
          if (half) begin
            link.sck <= ~link.sck;
            // command strobe set on falling sck, seen at next rise
            if (link.sck) begin
              link.cmd_valid <= pending;
              link.cmd_code <= hold_code;
              pending <= 1'b0;
            end
          end
          // taken after the strobe update so a new request is not lost
          if (req_in && !pending) begin
            if (block) begin
              refused_out <= 1'b1;
            end else begin
              pending <= 1'b1;
              hold_code <= req_code_in;
              link.cmd_addr <= req_addr_in;
              link.cmd_data <= req_data_in;
            end
          end
          if (pin_reset_in && !pending) begin
            hstate <= HS_RST_LOW;
            pulse_n <= 3'h0;
            ready_out <= 1'b0;
          end
        end
        HS_RST_LOW: begin
          link.sck <= 1'b0;
          link.cmd_valid <= 1'b0;
          if (half) begin
            link.cs_n <= 1'b0;
            link.si <= pulse_n[0];
            hstate <= HS_RST_HIGH;
          end
        end
        HS_RST_HIGH: begin
          if (half) begin
            link.cs_n <= 1'b1;
            pulse_n <= pulse_n + 3'h1;
            hstate <= pulse_n == 3'h3 ? HS_RUN : HS_RST_LOW;
          end
        end
        default: hstate <= HS_RUN;
      endcase
    end
  end
endmodule : fst_host

/* File: testbench/fst_assertions.sv */
// checker for the serial link between host and flash control
// assumes: instanced by the bench beside the link, sck runs in ops
`timescale 1ns/1ps
module fst_assertions import fst_pkg::*; (
  input wire logic rst_n_in,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic [8:0] cmd_addr,
  input wire logic busy,
  input wire logic [5:0] status
);
  // ==========================================================
  // windows in sck cycles
  localparam int T_LO = 10; // terminate latency window
  localparam int T_HI = 13;
  localparam int S_LO = 11; // suspend window minus quiet span
  localparam int S_HI = 14;
  localparam int L_HI = 66; // otp write plus margin
  // ==========================================================
  // decode helpers
  logic [7:0] op_code; // kind of the running operation
  wire term_cmd = cmd_valid && cmd_code == CMD_TERMINATE;
  wire susp_cmd = cmd_valid && cmd_code == CMD_SUSPEND;
  wire idle_ok = !busy && status[3:2] == 2'b00; // nothing suspended
  wire start_cmd = cmd_valid && !busy && (cmd_code inside {CMD_PROGRAM, CMD_ERASE,
    CMD_OTP_PROGRAM, CMD_WRITE_STATUS, CMD_STATUS_LOCK});
  wire op_prog = op_code == CMD_PROGRAM;
  wire op_erase = op_code == CMD_ERASE;
  wire is_nv = op_code inside {CMD_OTP_PROGRAM, CMD_WRITE_STATUS, CMD_STATUS_LOCK};
  // remember which operation was started last
  always_ff @(posedge sck or negedge rst_n_in) begin
    if (!rst_n_in) op_code <= 8'h00;
    else if (start_cmd) op_code <= cmd_code;
  end
  default clocking cb @(posedge sck); endclocking
  default disable iff (!rst_n_in);
  // ==========================================================
  // sequences and properties
  sequence s_quiet;
    (!term_cmd) [*8];
  endsequence
  sequence s_susp_prog;
    susp_cmd && busy && op_prog;
  endsequence
  sequence s_susp_erase;
    susp_cmd && busy && op_erase;
  endsequence
  a_busy_holds: assert property ((susp_cmd || term_cmd) && busy && !is_nv |=> busy [*8])
    else $error("busy fell early after suspend or terminate");
  a_term_prog_flag: assert property (term_cmd && busy && op_prog |->
    ##[T_LO:T_HI] (!busy && status[5] && !status[3])) else $error("program terminate flags");
  a_susp_prog_flag: assert property (s_susp_prog ##1 s_quiet |->
    ##[S_LO:S_HI] (!busy && status[3] && !status[5])) else $error("program suspend flags");
  a_term_erase_flag: assert property (term_cmd && busy && op_erase |->
    ##[T_LO:T_HI] (!busy && status[4] && !status[2])) else $error("erase terminate flags");
  a_susp_erase_flag: assert property (s_susp_erase ##1 s_quiet |->
    ##[S_LO:S_HI] (!busy && status[2] && !status[4])) else $error("erase suspend flags");
  a_term_after_susp: assert property (term_cmd && !busy && status[3:2] != 2'b00 |=>
    (!busy && $stable(status)) [*6]) else $error("terminate acted while suspended");
  a_term_nv_ignored: assert property (term_cmd && busy && is_nv |=>
    (busy && !status[5]) [*3]) else $error("terminate acted on register write");
  a_prog_clears_pe: assert property (cmd_valid && cmd_code == CMD_PROGRAM && idle_ok |->
    ##2 (busy && !status[5])) else $error("program did not clear error");
  a_erase_clears_ee: assert property (cmd_valid && cmd_code == CMD_ERASE && idle_ok |->
    ##2 (busy && !status[4])) else $error("erase did not clear error");
  a_otp_lock_bit: assert property (cmd_valid && cmd_code == CMD_OTP_PROGRAM && !busy &&
    cmd_addr[6:0] == OTP_MSB_INDEX && cmd_addr[8:7] != 2'b00 |-> ##[1:L_HI] status[1])
    else $error("lock bit not raised");
  a_cmd_cs_high: assert property (cmd_valid |-> cs_n)
    else $error("command strobe while chip select low");
endmodule : fst_assertions

/* File: testbench/testbench.sv */
// self-checking bench: host and device joined by the link
// assumes: host makes sck from clock_in, bench drives user side
`timescale 1ns/1ps
module testbench import fst_pkg::*;;
  localparam logic [7:0] MODE_CMD = 8'h38; // multi-line mode command
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic req_in = 1'b0;
  logic [7:0] req_code_in = 8'h00;
  logic [8:0] req_addr_in = 9'h000;
  logic [7:0] req_data_in = 8'hA5;
  logic pin_reset_in = 1'b0;
  logic ultra_sleep_in = 1'b0; // tied: not in ultra sleep
  logic [1:0] lines_req_in = 2'h0;
  logic ready_out, refused_out, reset_pulse_out;
  logic [2:0] security_lock_bits_out;
  logic [1:0] lines_mode_out;
  logic [7:0] otp_rdata_out;
  logic refused_seen, pulse_seen;
  int err_count = 0;
  int cmp_count = 0;
  fst_link_if fst_link_if_i ();
  fst_host fst_host_i (.clock_in(clock_in), .rst_n_in(rst_n_in), .link(fst_link_if_i),
    .req_in(req_in), .req_code_in(req_code_in), .req_addr_in(req_addr_in),
    .req_data_in(req_data_in), .pin_reset_in(pin_reset_in), .ready_out(ready_out),
    .refused_out(refused_out));
  fst_device fst_device_i (.clock_in(clock_in), .rst_n_in(rst_n_in), .link(fst_link_if_i),
    .ultra_sleep_in(ultra_sleep_in), .lines_req_in(lines_req_in),
    .security_lock_bits_out(security_lock_bits_out), .lines_mode_out(lines_mode_out),
    .reset_pulse_out(reset_pulse_out), .otp_rdata_out(otp_rdata_out));
  fst_assertions fst_assertions_i (.rst_n_in(rst_n_in), .sck(fst_link_if_i.sck),
    .cs_n(fst_link_if_i.cs_n), .cmd_valid(fst_link_if_i.cmd_valid),
    .cmd_code(fst_link_if_i.cmd_code), .cmd_addr(fst_link_if_i.cmd_addr),
    .busy(fst_link_if_i.busy), .status(fst_link_if_i.status));
  // ==========================================================
  // clock and watchdog
  initial begin
    forever #25 clock_in = ~clock_in;
  end
  initial begin
    repeat (60000) @(posedge clock_in);
    err_count++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    give_verdict();
  end
  // ==========================================================
  // tasks
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check
  // one host request, then watch for a refusal
  task automatic send(input logic [7:0] code, input logic [8:0] addr);
    int n;
    n = 0;
    while (ready_out !== 1'b1 && n < 400) begin
      @(negedge clock_in);
      n++;
    end
    @(posedge clock_in);
    req_code_in <= code;
    req_addr_in <= addr;
    req_in <= 1'b1;
    @(posedge clock_in);
    req_in <= 1'b0;
    refused_seen = 1'b0;
    repeat (12) begin
      @(negedge clock_in);
      if (refused_out === 1'b1) refused_seen = 1'b1;
    end
  endtask : send
  task automatic wait_idle(input int lim);
    int n;
    n = 0;
    while (fst_link_if_i.busy !== 1'b0 && n < lim) begin
      @(negedge clock_in);
      n++;
    end
    check({7'h00, fst_link_if_i.busy}, 8'h00, "busy cleared");
  endtask : wait_idle
  // flags in order pe, ee, ps, es
  task automatic flags(input logic [3:0] exp, input string what);
    check({4'h0, fst_link_if_i.status[5:2]}, {4'h0, exp}, what);
  endtask : flags
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict
  // ==========================================================
  // main sequence
  initial begin
    repeat (20) @(posedge clock_in);
    rst_n_in <= 1'b1;
    // program suspend, ignored terminate, refusal, resume
    send(CMD_PROGRAM, 9'h000);
    send(CMD_SUSPEND, 9'h000);
    wait_idle(400);
    flags(4'b0010, "program suspended");
    send(CMD_TERMINATE, 9'h000);
    repeat (60) @(negedge clock_in);
    flags(4'b0010, "terminate ignored");
    send(CMD_PROGRAM, 9'h000);
    check({7'h00, refused_seen}, 8'h01, "program refused");
    send(CMD_RESUME, 9'h000);
    wait_idle(1200);
    flags(4'b0000, "program done");
    $display("test program_suspend done");
    // terminate beats pending suspend, resume ignored
    send(CMD_PROGRAM, 9'h000);
    send(CMD_SUSPEND, 9'h000);
    send(CMD_TERMINATE, 9'h000);
    wait_idle(400);
    flags(4'b1000, "program error");
    send(CMD_RESUME, 9'h000);
    check({7'h00, fst_link_if_i.busy}, 8'h00, "no resume");
    send(CMD_PROGRAM, 9'h000);
    flags(4'b0000, "error cleared");
    send(CMD_TERMINATE, 9'h000);
    wait_idle(400);
    flags(4'b1000, "program terminated");
    $display("test program_terminate done");
    // erase suspend, resume and terminate, early terminate
    send(CMD_ERASE, 9'h000);
    send(CMD_SUSPEND, 9'h000);
    wait_idle(400);
    flags(4'b1001, "erase suspended");
    send(CMD_RESUME, 9'h000);
    send(CMD_TERMINATE, 9'h000);
    wait_idle(400);
    flags(4'b1100, "erase terminated");
    send(CMD_ERASE, 9'h000);
    flags(4'b1000, "erase error cleared");
    send(CMD_SUSPEND, 9'h000);
    send(CMD_TERMINATE, 9'h000);
    wait_idle(400);
    flags(4'b1100, "erase early terminate");
    $display("test erase done");
    // security registers
    send(CMD_OTP_PROGRAM, {2'b01, 7'h10});
    wait_idle(600);
    check({5'h00, security_lock_bits_out}, 8'h00, "no lock");
    send(CMD_OTP_PROGRAM, {2'b10, OTP_MSB_INDEX});
    send(CMD_TERMINATE, 9'h000);
    check({7'h00, fst_link_if_i.busy}, 8'h01, "otp write runs");
    wait_idle(600);
    check({5'h00, security_lock_bits_out}, 8'h02, "lock set");
    check(otp_rdata_out, 8'hA5, "otp byte");
    flags(4'b0100, "no error");
    send(CMD_OTP_PROGRAM, {2'b00, OTP_MSB_INDEX});
    wait_idle(600);
    check({5'h00, security_lock_bits_out}, 8'h02, "factory refused");
    $display("test security done");
    // pin-sequence reset, held off by a register write
    @(posedge clock_in);
    lines_req_in <= 2'b10;
    send(MODE_CMD, 9'h000);
    check({6'h00, lines_mode_out}, 8'h02, "multi-line");
    send(CMD_WRITE_STATUS, 9'h000);
    pulse_seen = 1'b0;
    // one-cycle request, so the host sends the sequence once
    @(posedge clock_in);
    pin_reset_in <= 1'b1;
    @(posedge clock_in);
    pin_reset_in <= 1'b0;
    for (int n = 0; n < 600 && !pulse_seen; n++) begin
      @(negedge clock_in);
      if (reset_pulse_out === 1'b1) pulse_seen = 1'b1;
    end
    check({7'h00, pulse_seen}, 8'h01, "reset seen");
    repeat (40) @(negedge clock_in);
    check({7'h00, fst_link_if_i.busy}, 8'h01, "write still runs");
    check({6'h00, lines_mode_out}, 8'h02, "reset postponed");
    wait_idle(600);
    repeat (40) @(negedge clock_in);
    check({6'h00, lines_mode_out}, 8'h00, "single line");
    flags(4'b0000, "flags reset");
    check({5'h00, security_lock_bits_out}, 8'h02, "locks kept");
    $display("test pin_reset done");
    // software reset clears the error flags
    send(CMD_ERASE, 9'h000);
    send(CMD_TERMINATE, 9'h000);
    wait_idle(400);
    flags(4'b0100, "erase error set");
    send(CMD_RESET_ENABLE, 9'h000);
    send(CMD_RESET_DEVICE, 9'h000);
    repeat (8) @(negedge clock_in);
    flags(4'b0000, "software reset");
    $display("test soft_reset done");
    give_verdict();
  end
endmodule : testbench
